// ===== design/mpb_pkg.sv
/*
 * Constants and types shared by the host-side pixel bus controller.
 * Assumes one 250 MHz system clock and a display that keeps its straps fixed.
 */
// Overview of operation
// - straps 101 select three-wire 9-bit serial link
// - straps 011 select 8-bit bus, low lines
// - straps 010 select 16-bit parallel bus
// - straps 000 select 18-bit parallel bus
// - format 101 is 5-6-5, 110 is 6-6-6
// - serial carries 6-6-6 only, colour bit 5 first
// - 8-bit 5-6-5 pixel takes two byte transfers
// - 8-bit 6-6-6 pixel takes three byte transfers
// - 16-bit 5-6-5 pixel takes one transfer
// - 5-6-5 lanes: green 6 bits, red/blue 5
// - 16-bit 6-6-6: three transfers carry two pixels
// - 18-bit bus: 6-6-6 only, one transfer each
package mpb_pkg;

    // ==========================================================
    // interface mode straps and pixel format field
    localparam logic [2:0] MPB_IM_SERIAL = 3'h5;
    localparam logic [2:0] MPB_IM_PAR8 = 3'h3;
    localparam logic [2:0] MPB_IM_PAR16 = 3'h2;
    localparam logic [2:0] MPB_IM_PAR18 = 3'h0;
    localparam logic [2:0] MPB_STRAP_RESET = 3'h7;
    localparam logic [2:0] MPB_FMT_565 = 3'h5;
    localparam logic [2:0] MPB_FMT_666 = 3'h6;
    localparam logic [7:0] MPB_CMD_PIXEL_FORMAT = 8'h3a;

    // ==========================================================
    // timing
    localparam int MPB_CLK_PERIOD_PS = 4000;
    localparam int MPB_T_WR_LOW_NS = 15;
    localparam int MPB_T_WR_HIGH_NS = 15;
    localparam int MPB_T_SCL_HALF_NS = 20;
    localparam int MPB_WR_LOW_CYC =
        (MPB_T_WR_LOW_NS * 1000 + MPB_CLK_PERIOD_PS - 1) / MPB_CLK_PERIOD_PS;
    localparam int MPB_WR_HIGH_CYC =
        (MPB_T_WR_HIGH_NS * 1000 + MPB_CLK_PERIOD_PS - 1) / MPB_CLK_PERIOD_PS;
    localparam int MPB_SCL_HALF_CYC =
        (MPB_T_SCL_HALF_NS * 1000 + MPB_CLK_PERIOD_PS - 1) / MPB_CLK_PERIOD_PS;
    localparam logic [3:0] MPB_SER_LAST_BIT = 4'h8;

    // ==========================================================
    // types
    typedef struct packed {
        logic is_cmd;
        logic [17:0] data;
    } mpb_req_t;

    typedef struct packed {
        logic dc;
        logic [17:0] data;
    } mpb_word_t;

    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } mpb_rgb_t;

    typedef struct packed {
        logic cs_n;
        logic dc;
        logic wr_n;
        logic rd_n;
        logic [17:0] data;
        logic data_oe;
        logic scl;
        logic sda;
        logic sda_oe;
    } mpb_pins_t;

    typedef enum logic [1:0] {
        MPB_S_IDLE = 2'h0,
        MPB_S_LOW = 2'h1,
        MPB_S_HIGH = 2'h3
    } mpb_state_t;

endpackage

// ===== design/mpb_strap_sync.sv
/*
 * Two-stage synchroniser for the strap pins.
 * Assumes the straps are static; only their settled level matters.
 */
`timescale 1ns/1ps
module mpb_strap_sync #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk_in, // system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pin levels
    output logic [WIDTH-1:0] sync_out // settled levels
);
    import mpb_pkg::*;

    // ==========================================================
    // per-bit flop pairs
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            // reset value is an unused mode so no transfer starts early
            always_ff @(posedge sys_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    meta_reg <= MPB_STRAP_RESET[i % 3];
                    sync_reg <= MPB_STRAP_RESET[i % 3];
                end else begin
                    meta_reg <= async_in[i];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_out[i] = sync_reg;
        end
    endgenerate

endmodule

// ===== design/mpb_serial_tx.sv
/*
 * Three-wire 9-bit serial shifter: select bit first, then eight data bits.
 * Assumes the caller holds chip select low around the whole word.
 */
`timescale 1ns/1ps
module mpb_serial_tx (
    input wire logic sys_clk_in, // system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic start_in, // one-cycle start pulse
    input wire logic [8:0] word_in, // select bit and byte
    output logic scl_out, // serial clock
    output logic sda_out, // serial data
    output logic sda_oe_out, // data pin driven
    output logic done_out // one-cycle end pulse
);
    import mpb_pkg::*;

    logic busy_reg, busy_next;
    logic [8:0] shift_reg, shift_next;
    logic [3:0] bit_reg, bit_next;
    logic [3:0] half_reg, half_next;
    logic scl_reg, scl_next;
    logic done_reg, done_next;

    wire half_end = (half_reg == 4'h0);

    // ==========================================================
    // shifter: data changes on falling clock, device samples on rising
    always_comb begin
        busy_next = busy_reg;
        shift_next = shift_reg;
        bit_next = bit_reg;
        half_next = half_reg;
        scl_next = scl_reg;
        done_next = 1'b0;
        if (start_in) begin
            busy_next = 1'b1;
            shift_next = word_in;
            bit_next = 4'h0;
            half_next = 4'(MPB_SCL_HALF_CYC - 1);
            scl_next = 1'b0;
        end else if (busy_reg) begin
            if (!half_end) begin
                half_next = half_reg - 4'h1;
            end else begin
                half_next = 4'(MPB_SCL_HALF_CYC - 1);
                scl_next = ~scl_reg;
                if (scl_reg) begin
                    if (bit_reg == MPB_SER_LAST_BIT) begin
                        busy_next = 1'b0;
                        done_next = 1'b1;
                    end else begin
                        shift_next = {shift_reg[7:0], 1'b0};
                        bit_next = bit_reg + 4'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_reg <= 1'b0;
            shift_reg <= 9'h000;
            bit_reg <= 4'h0;
            half_reg <= 4'h0;
            scl_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            half_reg <= half_next;
            scl_reg <= scl_next;
            done_reg <= done_next;
        end
    end

    assign scl_out = scl_reg;
    assign sda_out = shift_reg[8];
    assign sda_oe_out = busy_reg;
    assign done_out = done_reg;

endmodule

// ===== design/mpb_host.sv
/*
 * Host-side pixel write controller: takes pixels and command bytes from
 * user logic and packs them onto the display's serial or parallel link.
 * Assumes the straps match the display's and the format input matches
 * what software last wrote to the display's pixel format command.
 */
`timescale 1ns/1ps
module mpb_host (
    input wire logic sys_clk_in, // system clock, 250 MHz
    input wire logic resetn_in, // async reset, active low
    input wire logic [2:0] interface_mode_straps_in, // strap pins (async)
    input wire logic [2:0] host_pixel_format_field_in, // current pixel format
    input wire logic req_valid_in, // request offered
    input wire mpb_pkg::mpb_req_t req_in, // command byte or pixel
    output logic req_ready_out, // request taken when valid too
    output logic busy_out, // a unit is on the link
    output mpb_pkg::mpb_pins_t pins_out // display pins
);
    import mpb_pkg::*;

    // ==========================================================
    // mode and format decode
    logic [2:0] mode_sync;

    mpb_strap_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .async_in(interface_mode_straps_in),
        .sync_out(mode_sync)
    );

    wire mode_ser = (mode_sync == MPB_IM_SERIAL);
    wire mode_p8 = (mode_sync == MPB_IM_PAR8);
    wire mode_p16 = (mode_sync == MPB_IM_PAR16);
    wire mode_p18 = (mode_sync == MPB_IM_PAR18);
    wire mode_ok = mode_ser | mode_p8 | mode_p16 | mode_p18;
    // anything but 5-6-5 is treated as 6-6-6
    wire fmt_565 = (host_pixel_format_field_in == MPB_FMT_565);

    // ==========================================================
    // helpers
    function automatic mpb_rgb_t expand_565(input logic [15:0] p);
        // the link needs 6-bit colours; widen the same way the display does
        expand_565.red = {p[15:11], p[15]};
        expand_565.green = p[10:5];
        expand_565.blue = {p[4:0], p[4]};
    endfunction

    function automatic mpb_word_t color_byte(input logic [5:0] c);
        color_byte = {1'b1, 10'h000, c, 2'h0};
    endfunction

    function automatic mpb_word_t color_pair(input logic [5:0] a, input logic [5:0] b);
        color_pair = {1'b1, 2'h0, a, 2'h0, b, 2'h0};
    endfunction

    // ==========================================================
    // state
    mpb_state_t state_reg, state_next;
    mpb_word_t [2:0] words_reg, words_next;
    logic [1:0] n_reg, n_next;
    logic [1:0] idx_reg, idx_next;
    logic [3:0] cnt_reg, cnt_next;
    logic pend_reg, pend_next;
    logic [5:0] pend_blue_reg, pend_blue_next;
    logic cs_n_reg, cs_n_next;
    logic dc_reg, dc_next;
    logic wr_n_reg, wr_n_next;
    logic [17:0] data_reg, data_next;
    logic data_oe_reg, data_oe_next;

    // ==========================================================
    // unit builder
    mpb_rgb_t rgb;
    mpb_word_t cmd_word;
    mpb_word_t [2:0] load_words;
    logic [1:0] load_n;
    logic load_pend;
    logic [5:0] load_blue;

    assign rgb = fmt_565 ? expand_565(req_in.data[15:0]) : mpb_rgb_t'(req_in.data);
    assign cmd_word = {1'b0, 10'h000, req_in.data[7:0]};

    always_comb begin
        load_words = '0;
        load_n = 2'h1;
        load_pend = pend_reg;
        load_blue = pend_blue_reg;
        if (req_in.is_cmd) begin
            // half pixel left over: flush it padded so the command is not mixed in
            if (pend_reg) begin
                load_words[0] = {1'b1, 2'h0, pend_blue_reg, 2'h0, 8'h00};
                load_words[1] = cmd_word;
                load_n = 2'h2;
                load_pend = 1'b0;
            end else begin
                load_words[0] = cmd_word;
            end
        end else if (mode_ser || (mode_p8 && !fmt_565)) begin
            load_words[0] = color_byte(rgb.red);
            load_words[1] = color_byte(rgb.green);
            load_words[2] = color_byte(rgb.blue);
            load_n = 2'h3;
        end else if (mode_p8) begin
            load_words[0] = {1'b1, 10'h000, req_in.data[15:8]};
            load_words[1] = {1'b1, 10'h000, req_in.data[7:0]};
            load_n = 2'h2;
        end else if (mode_p16 && fmt_565) begin
            load_words[0] = {1'b1, 2'h0, req_in.data[15:0]};
        end else if (mode_p16) begin
            if (!pend_reg) begin
                load_words[0] = color_pair(rgb.red, rgb.green);
                load_pend = 1'b1;
                load_blue = rgb.blue;
            end else begin
                load_words[0] = color_pair(pend_blue_reg, rgb.red);
                load_words[1] = color_pair(rgb.green, rgb.blue);
                load_n = 2'h2;
                load_pend = 1'b0;
            end
        end else begin
            load_words[0] = {1'b1, rgb};
        end
    end

    // ==========================================================
    // transfer sequencing
    logic tx_done;
    logic ser_scl, ser_sda, ser_sda_oe;
    wire accept = req_valid_in && req_ready_out;
    wire cnt_zero = (cnt_reg == 4'h0);
    wire more = ((idx_reg + 2'h1) != n_reg);
    wire next_go = (state_reg == MPB_S_HIGH) && cnt_zero && more;
    wire launch = accept || next_go;
    wire mpb_word_t launch_word = accept ? load_words[0] : words_reg[idx_reg + 2'h1];
    wire tx_start = launch && mode_ser;
    wire unit_done = (state_reg == MPB_S_HIGH) && cnt_zero && !more;

    mpb_serial_tx u_serial_tx (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .start_in(tx_start),
        .word_in({launch_word.dc, launch_word.data[7:0]}),
        .scl_out(ser_scl),
        .sda_out(ser_sda),
        .sda_oe_out(ser_sda_oe),
        .done_out(tx_done)
    );

    always_comb begin
        state_next = state_reg;
        words_next = words_reg;
        n_next = n_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        pend_blue_next = pend_blue_reg;
        cs_n_next = cs_n_reg;
        dc_next = dc_reg;
        wr_n_next = wr_n_reg;
        data_next = data_reg;
        data_oe_next = data_oe_reg;
        case (state_reg)
            MPB_S_IDLE: begin
                if (accept) begin
                    words_next = load_words;
                    n_next = load_n;
                    idx_next = 2'h0;
                    pend_next = load_pend;
                    pend_blue_next = load_blue;
                    cs_n_next = 1'b0;
                    state_next = MPB_S_LOW;
                end
            end
            MPB_S_LOW: begin
                if (mode_ser) begin
                    if (tx_done) begin
                        cnt_next = 4'(MPB_WR_HIGH_CYC - 1);
                        state_next = MPB_S_HIGH;
                    end
                end else if (cnt_zero) begin
                    wr_n_next = 1'b1;
                    cnt_next = 4'(MPB_WR_HIGH_CYC - 1);
                    state_next = MPB_S_HIGH;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            MPB_S_HIGH: begin
                if (!cnt_zero) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (more) begin
                    idx_next = idx_reg + 2'h1;
                    state_next = MPB_S_LOW;
                end else begin
                    cs_n_next = 1'b1;
                    data_oe_next = 1'b0;
                    state_next = MPB_S_IDLE;
                end
            end
            default: begin
                state_next = MPB_S_IDLE;
            end
        endcase
        if (launch) begin
            dc_next = launch_word.dc;
            cnt_next = 4'(MPB_WR_LOW_CYC - 1);
            if (!mode_ser) begin
                data_next = launch_word.data;
                wr_n_next = 1'b0;
                data_oe_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= MPB_S_IDLE;
            words_reg <= '0;
            n_reg <= 2'h1;
            idx_reg <= 2'h0;
            cnt_reg <= 4'h0;
            pend_reg <= 1'b0;
            pend_blue_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            words_reg <= words_next;
            n_reg <= n_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            pend_blue_reg <= pend_blue_next;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cs_n_reg <= 1'b1;
            dc_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            data_reg <= 18'h00000;
            data_oe_reg <= 1'b0;
        end else begin
            cs_n_reg <= cs_n_next;
            dc_reg <= dc_next;
            wr_n_reg <= wr_n_next;
            data_reg <= data_next;
            data_oe_reg <= data_oe_next;
        end
    end

    // ==========================================================
    // outputs
    assign req_ready_out = (state_reg == MPB_S_IDLE) && mode_ok;
    assign busy_out = (state_reg != MPB_S_IDLE);
    assign pins_out.cs_n = cs_n_reg;
    assign pins_out.dc = dc_reg;
    assign pins_out.wr_n = wr_n_reg;
    assign pins_out.rd_n = 1'b1; // reads are not supported
    assign pins_out.data = data_reg;
    assign pins_out.data_oe = data_oe_reg;
    assign pins_out.scl = ser_scl;
    assign pins_out.sda = ser_sda;
    assign pins_out.sda_oe = ser_sda_oe;

    // ==========================================================
    // checks
    logic wr_prev_reg;
    logic [1:0] fall_cnt_reg;
    logic u_cmd_reg, u_pend_reg;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_prev_reg <= 1'b1;
            fall_cnt_reg <= 2'h0;
            u_cmd_reg <= 1'b0;
            u_pend_reg <= 1'b0;
        end else begin
            wr_prev_reg <= wr_n_reg;
            if (accept) begin
                fall_cnt_reg <= 2'h0;
                u_cmd_reg <= req_in.is_cmd;
                u_pend_reg <= pend_reg;
            end else if (wr_prev_reg && !wr_n_reg) begin
                fall_cnt_reg <= fall_cnt_reg + 2'h1;
            end
        end
    end

    wire pix_done = unit_done && !u_cmd_reg;

    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_cmd_strobe;
        (!pins_out.dc && !pins_out.wr_n) [*4] ##1 pins_out.wr_n;
    endsequence

    sequence s_serial_start;
        pins_out.wr_n && pins_out.sda_oe && !pins_out.cs_n;
    endsequence

    a_serial_no_strobe: assert property (
        accept && mode_ser |=> s_serial_start)
        else $error("serial unit did not start on the serial pins");
    a_bus8_upper_idle: assert property (
        !pins_out.wr_n && mode_p8 |-> pins_out.data[17:8] == 10'h000)
        else $error("8-bit bus drove upper data lines");
    a_bus16_top_idle: assert property (
        !pins_out.wr_n && mode_p16 |-> pins_out.data[17:16] == 2'h0)
        else $error("16-bit bus drove lines 17 and 16");
    a_pix18_one_xfer: assert property (
        pix_done && mode_p18 |-> fall_cnt_reg == 2'h1)
        else $error("18-bit pixel not one transfer");
    a_pix8_two_xfers: assert property (
        pix_done && mode_p8 && fmt_565 |-> fall_cnt_reg == 2'h2)
        else $error("8-bit 5-6-5 pixel not two transfers");
    a_pix8_three_xfers: assert property (
        pix_done && mode_p8 && !fmt_565 |-> fall_cnt_reg == 2'h3)
        else $error("8-bit 6-6-6 pixel not three transfers");
    a_pix16_one_xfer: assert property (
        pix_done && mode_p16 && fmt_565 |-> fall_cnt_reg == 2'h1)
        else $error("16-bit 5-6-5 pixel not one transfer");
    a_pix16_pair_xfers: assert property (
        pix_done && mode_p16 && !fmt_565 |-> fall_cnt_reg == (u_pend_reg ? 2'h2 : 2'h1))
        else $error("16-bit 6-6-6 pixel pair not three transfers");
    a_565_pixel_lanes: assert property (
        accept && !req_in.is_cmd && mode_p16 && fmt_565
        |=> pins_out.dc && pins_out.data[15:0] == $past(req_in.data[15:0]))
        else $error("5-6-5 pixel lanes wrong");
    a_cmd_dc_low: assert property (
        accept && req_in.is_cmd && !pend_reg && !mode_ser |=> s_cmd_strobe)
        else $error("command byte not sent with select low");
    a_serial_color_msb: assert property (
        accept && !req_in.is_cmd && mode_ser
        |=> words_reg[0].data[7:0] == {$past(rgb.red), 2'h0}
            && words_reg[2].data[7:2] == $past(rgb.blue))
        else $error("serial colour not MSB aligned");

endmodule

// ===== tb/mpb_dev_model.sv
/*
 * Display-side model: latches each parallel write strobe or serial word.
 * Assumes the strap levels stay fixed while the host is out of reset.
 */
`timescale 1ns/1ps
module mpb_dev_model (
    input wire logic sys_clk_in, // system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic [2:0] interface_mode_straps_in, // strap levels
    input wire mpb_pkg::mpb_pins_t pins_in, // pins from the host
    output logic word_valid_out, // one-cycle word strobe
    output mpb_pkg::mpb_word_t word_out // received word
);
    import mpb_pkg::*;
    logic wr_n_reg, scl_reg, dc_reg, is_serial;
    logic [7:0] shift_reg;
    logic [3:0] count_reg;
    logic [17:0] lat_reg, lane_mask;
    // =========================================================
    // lane decode: unwired lines read as zero
    assign is_serial = interface_mode_straps_in == MPB_IM_SERIAL;
    assign lane_mask = (interface_mode_straps_in == MPB_IM_PAR8) ? 18'h000ff :
        (interface_mode_straps_in == MPB_IM_PAR16) ? 18'h0ffff : 18'h3ffff;
    // =========================================================
    // capture
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_valid_out <= 1'b0;
            word_out <= '0;
            {wr_n_reg, scl_reg, dc_reg} <= 3'h7;
            {shift_reg, count_reg, lat_reg} <= '0;
        end else begin
            word_valid_out <= 1'b0;
            wr_n_reg <= pins_in.wr_n;
            scl_reg <= pins_in.scl;
            if (!pins_in.wr_n) begin
                lat_reg <= pins_in.data & lane_mask;
                dc_reg <= pins_in.dc;
            end
            // data taken at the rising strobe edge, select line with it
            if (!is_serial && pins_in.wr_n && !wr_n_reg && !pins_in.cs_n) begin
                word_valid_out <= 1'b1;
                word_out <= {dc_reg, lat_reg};
            end
            if (!is_serial || pins_in.cs_n) begin
                count_reg <= 4'h0;
            end else if (pins_in.scl && !scl_reg) begin
                shift_reg <= {shift_reg[6:0], pins_in.sda};
                count_reg <= (count_reg == 4'h8) ? 4'h0 : count_reg + 4'h1;
                if (count_reg == 4'h8) begin
                    word_valid_out <= 1'b1;
                    word_out <= {shift_reg[7], 10'h0, shift_reg[6:0], pins_in.sda};
                end
            end
        end
    end
endmodule

// ===== tb/test_mcu_pixel_bus_packing.sv
/*
 * Self-checking bench: every strap mode and pixel format, words compared.
 * Assumes the design and model files are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_mcu_pixel_bus_packing;
    import mpb_pkg::*;
    logic sys_clk_in, resetn_in, req_valid_in, req_ready_out, busy_out, word_valid, half_on;
    logic [2:0] straps, fmt;
    logic [5:0] half_b;
    logic [18:0] exp_w;
    logic [31:0] seed;
    mpb_req_t req_in;
    mpb_pins_t pins;
    mpb_word_t got_word;
    logic [18:0] exp_q[$];
    int err_total, checks_done, cyc, i;
    mpb_host i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .interface_mode_straps_in(straps), .host_pixel_format_field_in(fmt),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .busy_out(busy_out), .pins_out(pins));
    mpb_dev_model i_dev (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .interface_mode_straps_in(straps), .pins_in(pins), .word_valid_out(word_valid),
        .word_out(got_word));
    // =========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task test_done();
        if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task push3(input logic [5:0] a, b, c);
        exp_q.push_back({1'b1, 10'h0, a, 2'h0});
        exp_q.push_back({1'b1, 10'h0, b, 2'h0});
        exp_q.push_back({1'b1, 10'h0, c, 2'h0});
    endtask
    // expected bus words of one request, in order
    task push_exp(input mpb_req_t r);
        logic [5:0] rc, gc, bc;
        if (r.is_cmd) begin
            if (half_on) exp_q.push_back({1'b1, 2'h0, half_b, 2'h0, 8'h00});
            half_on = 1'b0;
            exp_q.push_back({1'b0, 10'h0, r.data[7:0]});
        end else begin
            if (fmt == MPB_FMT_565) begin
                rc = {r.data[15:11], r.data[15]};
                gc = r.data[10:5];
                bc = {r.data[4:0], r.data[4]};
            end else {rc, gc, bc} = r.data;
            if (straps == MPB_IM_SERIAL) push3(rc, gc, bc);
            else if (straps == MPB_IM_PAR8 && fmt != MPB_FMT_565) push3(rc, gc, bc);
            else if (straps == MPB_IM_PAR8) begin
                exp_q.push_back({1'b1, 10'h0, r.data[15:8]});
                exp_q.push_back({1'b1, 10'h0, r.data[7:0]});
            end else if (straps == MPB_IM_PAR16 && fmt == MPB_FMT_565)
                exp_q.push_back({1'b1, 2'h0, r.data[15:0]});
            else if (straps == MPB_IM_PAR16 && !half_on) begin
                exp_q.push_back({1'b1, 2'h0, rc, 2'h0, gc, 2'h0});
                half_b = bc;
                half_on = 1'b1;
            end else if (straps == MPB_IM_PAR16) begin
                exp_q.push_back({1'b1, 2'h0, half_b, 2'h0, rc, 2'h0});
                exp_q.push_back({1'b1, 2'h0, gc, 2'h0, bc, 2'h0});
                half_on = 1'b0;
            end else exp_q.push_back({1'b1, rc, gc, bc});
        end
    endtask
    // valid stays up between requests so it never toggles twice in a step
    task send(input logic is_cmd);
        int n;
        seed = xs(seed);
        req_in = {is_cmd, is_cmd ? {10'h0, seed[7:0]} :
            (fmt == MPB_FMT_565 ? {2'h0, seed[15:0]} : seed[17:0])};
        push_exp(req_in);
        req_valid_in = 1'b1;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        @(posedge sys_clk_in);
        #1;
    endtask
    task run_case(input logic [2:0] m, input logic [2:0] f);
        int n;
        @(posedge sys_clk_in);
        #1;
        resetn_in = 1'b0;
        straps = m;
        fmt = f;
        half_on = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        resetn_in = 1'b1;
        repeat (8) @(posedge sys_clk_in);
        #1;
        if (m == MPB_STRAP_RESET) begin
            `CHK(req_ready_out, 1'b0)
            return;
        end
        for (i = 0; i < 7; i++) send(i == 0 || i == 5);
        send(1'b1);
        req_valid_in = 1'b0;
        n = 0;
        while ((busy_out !== 1'b0 || exp_q.size() != 0) && n < 4000) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        `CHK(exp_q.size() != 0, 1'b0)
        `CHK(busy_out, 1'b0)
    endtask
    // =========================================================
    // clock, watchdog, word compare, main sequence
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end
    always @(negedge sys_clk_in) begin
        if (word_valid === 1'b1) begin
            exp_w = exp_q.size() ? exp_q.pop_front() : 19'bx;
            `CHK(got_word, exp_w)
        end
    end
    initial begin
        {resetn_in, req_valid_in, half_on, half_b, req_in} = '0;
        {err_total, checks_done, cyc} = '0;
        straps = MPB_IM_SERIAL;
        fmt = MPB_FMT_666;
        seed = 32'hf7614091;
        run_case(MPB_STRAP_RESET, MPB_FMT_666);
        run_case(MPB_IM_SERIAL, MPB_FMT_666);
        run_case(MPB_IM_SERIAL, MPB_FMT_565);
        run_case(MPB_IM_PAR8, MPB_FMT_565);
        run_case(MPB_IM_PAR8, MPB_FMT_666);
        run_case(MPB_IM_PAR16, MPB_FMT_565);
        run_case(MPB_IM_PAR16, MPB_FMT_666);
        run_case(MPB_IM_PAR18, MPB_FMT_666);
        run_case(MPB_IM_PAR18, MPB_FMT_565);
        test_done();
    end
endmodule
